// file: design/wolfd_crc32.sv
// Byte-wide reflected CRC-32 update step
`default_nettype none
`include "wolfd_cfg.svh"
module wolfd_crc32 (
  // Running value and new byte
  input  wire logic [31:0] i_crc,
  input  wire logic [7:0]  i_byte,
  // Updated value
  output logic      [31:0] o_crc
);
  logic [31:0] c;

  // Shift the byte in, least significant bit first
  always_comb begin
    c = i_crc;
    for (int k = 0; k < 8; k++) begin
      if (c[0] ^ i_byte[k]) begin
        c = (c >> 1) ^ `WOLFD_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    o_crc = c;
  end
endmodule : wolfd_crc32
`default_nettype wire

// file: design/wolfd_top.sv
// Wake-frame detector with APB register file
`default_nettype none
`include "wolfd_cfg.svh"
module wolfd_top
  import wolfd_pkg::*;
(
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST_N,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Received frame bytes
  input  wire logic        I_RX_EN,
  input  wire logic        I_RX_VLD,
  input  wire logic [7:0]  I_RX_BYTE,
  // Wake outputs
  output logic             O_IRQ,
  output logic             O_WAKE_GPIO
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // Registers
  logic [`WOLFD_CFG_W-1:0] cfg_q;
  logic [`WOLFD_STS_W-1:0] sts_q;
  logic [`WOLFD_STS_W-1:0] sts_d;
  logic [`WOLFD_STS_W-1:0] mask_q;
  logic [31:0]             maclo_q;
  logic [15:0]             machi_q;
  logic [31:0]             pwdlo_q;
  logic [15:0]             pwdhi_q;
  logic [31:0]             pmlo_q;
  logic [31:0]             pmhi_q;
  logic [31:0]             pat_q [16];
  logic                    pready_q;
  logic                    pslverr_q;
  logic [31:0]             prdata_q;
  logic [31:0]             rdata;
  logic                    irq_q;
  logic                    gpio_q;

  // Bus decode
  wire       acc    = I_PSEL & I_PENABLE;
  wire [9:0] idx    = I_PADDR[11:2];
  wire       is_cfg = idx == `WOLFD_IDX_CFG;
  wire       is_sts = idx == `WOLFD_IDX_STS;
  wire       is_msk = idx == `WOLFD_IDX_MASK;
  wire       is_mlo = idx == `WOLFD_IDX_MACLO;
  wire       is_mhi = idx == `WOLFD_IDX_MACHI;
  wire       is_plo = idx == `WOLFD_IDX_PWDLO;
  wire       is_phi = idx == `WOLFD_IDX_PWDHI;
  wire       is_klo = idx == `WOLFD_IDX_PMLO;
  wire       is_khi = idx == `WOLFD_IDX_PMHI;
  wire       is_pat = idx[9:4] == `WOLFD_IDX_PAT;
  wire       mapped = is_cfg | is_sts | is_msk | is_mlo | is_mhi
                    | is_plo | is_phi | is_klo | is_khi | is_pat;
  wire       wr     = acc & pready_q & I_PWRITE & mapped;
  wire       sts_clr_any = wr & is_sts;

  // Read data selection
  always_comb begin
    if (is_cfg) begin
      rdata = {{(32-`WOLFD_CFG_W){1'b0}}, cfg_q}; // see R13
    end else if (is_sts) begin
      rdata = {{(32-`WOLFD_STS_W){1'b0}}, sts_q}; // see R13
    end else if (is_msk) begin
      rdata = {{(32-`WOLFD_STS_W){1'b0}}, mask_q};
    end else if (is_mlo) begin
      rdata = maclo_q;
    end else if (is_mhi) begin
      rdata = {16'h0000, machi_q};
    end else if (is_plo) begin
      rdata = pwdlo_q;
    end else if (is_phi) begin
      rdata = {16'h0000, pwdhi_q};
    end else if (is_klo) begin
      rdata = pmlo_q;
    end else if (is_khi) begin
      rdata = pmhi_q;
    end else if (is_pat) begin
      rdata = pat_q[idx[3:0]];
    end else begin
      rdata = 32'h0000_0000;
    end
  end

  // One wait state, then the answer
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      prdata_q  <= (acc & ~pready_q & ~I_PWRITE) ? rdata : 32'h0000_0000;
    end
  end

  // Control registers written by software
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_q   <= `WOLFD_CFG_RST;
      mask_q  <= `WOLFD_STS_RST;
      maclo_q <= 32'h0000_0000;
      machi_q <= 16'h0000;
      pwdlo_q <= 32'h0000_0000;
      pwdhi_q <= 16'h0000;
      pmlo_q  <= 32'h0000_0000;
      pmhi_q  <= 32'h0000_0000;
    end else if (wr) begin
      if (is_cfg) cfg_q <= I_PWDATA[`WOLFD_CFG_W-1:0]; // see R13
      if (is_msk) mask_q <= I_PWDATA[`WOLFD_STS_W-1:0];
      if (is_mlo) maclo_q <= I_PWDATA;
      if (is_mhi) machi_q <= I_PWDATA[15:0];
      if (is_plo) pwdlo_q <= I_PWDATA;
      if (is_phi) pwdhi_q <= I_PWDATA[15:0];
      if (is_klo) pmlo_q <= I_PWDATA;
      if (is_khi) pmhi_q <= I_PWDATA;
    end
  end

  // Pattern memory, one word per entry
  for (genvar g = 0; g < 16; g++) begin : g_pat
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        pat_q[g] <= 32'h0000_0000;
      end else if (wr && is_pat && idx[3:0] == 4'(g)) begin
        pat_q[g] <= I_PWDATA;
      end
    end
  end

  // Config bits
  wire en_magic = cfg_q[`WOLFD_CFG_MAGIC];
  wire en_bcast = cfg_q[`WOLFD_CFG_BCAST];
  wire en_ucast = cfg_q[`WOLFD_CFG_UCAST];
  wire en_pwd   = cfg_q[`WOLFD_CFG_PWD];
  wire en_pat   = cfg_q[`WOLFD_CFG_PAT];
  wire en_gpio  = cfg_q[`WOLFD_CFG_GPIO];

  // Per-frame state
  logic         rx_en_q;
  logic [6:0]   cnt_q;
  logic [31:0]  crc_q;
  logic         uc_q;
  logic         bc_q;
  logic         pat_ok_q;
  logic         hit_q;
  wolfd_phase_t phase_q;
  wolfd_phase_t phase_d;
  logic [2:0]   sync_q;
  logic [2:0]   sync_d;
  logic [2:0]   ab_q;
  logic [2:0]   ab_d;
  logic [3:0]   cp_q;
  logic [3:0]   cp_d;
  logic [2:0]   pw_q;
  logic [2:0]   pw_d;
  logic         hit_d;
  logic [31:0]  crc_nx;

  // Frame edges; a fresh frame starts from initial values
  wire sof = I_RX_EN & ~rx_en_q;
  wire eof = ~I_RX_EN & rx_en_q;
  wire vld = I_RX_EN & I_RX_VLD;
  wire [7:0] b = I_RX_BYTE;
  wire is_ff = b == `WOLFD_SYNC_BYTE;

  wire [6:0]   cnt_c  = sof ? 7'h00 : cnt_q;
  wire [31:0]  crc_c  = sof ? `WOLFD_CRC_INIT : crc_q;
  wire         uc_c   = sof | uc_q;
  wire         bc_c   = sof | bc_q;
  wire         pok_c  = sof | pat_ok_q;
  wire         hit_c  = ~sof & hit_q;
  wolfd_phase_t phase_c;
  assign phase_c = sof ? WOLFD_SYNC : phase_q;
  wire [2:0]   sync_c = sof ? 3'h0 : sync_q;
  wire [2:0]   ab_c   = sof ? 3'h0 : ab_q;
  wire [3:0]   cp_c   = sof ? 4'h0 : cp_q;
  wire [2:0]   pw_c   = sof ? 3'h0 : pw_q;

  // Expected bytes: station address and password, first byte lowest
  wire [47:0] station = {machi_q, maclo_q};
  wire [47:0] passwd  = {pwdhi_q, pwdlo_q};
  wire [7:0]  mac_b   = station[{ab_c, 3'b000} +: 8];
  wire [7:0]  da_b    = station[{cnt_c[2:0], 3'b000} +: 8];
  wire [7:0]  pwd_b   = passwd[{pw_c, 3'b000} +: 8];
  wire [63:0] pmask   = {pmhi_q, pmlo_q};
  wire [31:0] pword   = pat_q[cnt_c[5:2]];
  wire [7:0]  pat_b   = pword[{cnt_c[1:0], 3'b000} +: 8];
  wire        in_da   = cnt_c < `WOLFD_DA_LEN;
  wire        in_pat  = cnt_c < `WOLFD_PAT_LEN;
  wire        pat_bad = in_pat & pmask[cnt_c[5:0]] & (b != pat_b);
  // Scan from the payload on, at any byte offset; the byte strobe
  // hides the line rate, so all three speeds share this path
  wire        scan    = vld & en_magic & (cnt_c >= `WOLFD_HDR_LEN); // see R1 R6 R10
  wire        restart_ff = is_ff;

  wolfd_crc32 u_crc (
    .i_crc  (crc_c),
    .i_byte (b),
    .o_crc  (crc_nx)
  );

  // Sequence hunt: sync run, address copies, optional password
  always_comb begin
    phase_d = phase_c;
    sync_d  = sync_c;
    ab_d    = ab_c;
    cp_d    = cp_c;
    pw_d    = pw_c;
    hit_d   = hit_c;
    if (scan) begin
      case (phase_c)
        WOLFD_SYNC: begin
          if (is_ff) begin
            if (sync_c != `WOLFD_SYNC_LEN) sync_d = sync_c + 3'h1; // see R3
          end else if (sync_c == `WOLFD_SYNC_LEN && b == mac_b) begin
            phase_d = WOLFD_ADDR; // see R3 R4
            ab_d    = 3'h1;
            cp_d    = 4'h0;
          end else begin
            sync_d = 3'h0; // see R14
          end
        end
        WOLFD_ADDR: begin
          if (b != mac_b) begin
            phase_d = WOLFD_SYNC; // see R4 R14
            sync_d  = restart_ff ? 3'h1 : 3'h0;
            ab_d    = 3'h0;
          end else if (ab_c != `WOLFD_ADDR_LAST) begin
            ab_d = ab_c + 3'h1;
          end else if (cp_c != `WOLFD_COPY_LAST) begin
            ab_d = 3'h0;
            cp_d = cp_c + 4'h1; // see R4
          end else if (en_pwd) begin
            ab_d    = 3'h0;
            pw_d    = 3'h0;
            phase_d = WOLFD_PWD; // see R5
          end else begin
            ab_d    = 3'h0;
            sync_d  = 3'h0;
            hit_d   = 1'b1;
            phase_d = WOLFD_SYNC;
          end
        end
        WOLFD_PWD: begin
          if (b != pwd_b) begin
            phase_d = WOLFD_SYNC; // see R14
            sync_d  = restart_ff ? 3'h1 : 3'h0;
          end else if (pw_c != `WOLFD_PWD_LAST) begin
            pw_d = pw_c + 3'h1; // see R14
          end else begin
            hit_d   = 1'b1; // see R5
            sync_d  = 3'h0;
            phase_d = WOLFD_SYNC;
          end
        end
        default: begin
          phase_d = WOLFD_SYNC;
          sync_d  = 3'h0;
          ab_d    = 3'h0;
        end
      endcase
    end
  end

  // Per-frame registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_en_q  <= 1'b0;
      cnt_q    <= 7'h00;
      crc_q    <= `WOLFD_CRC_INIT;
      uc_q     <= 1'b0;
      bc_q     <= 1'b0;
      pat_ok_q <= 1'b0;
      hit_q    <= 1'b0;
      phase_q  <= WOLFD_SYNC;
      sync_q   <= 3'h0;
      ab_q     <= 3'h0;
      cp_q     <= 4'h0;
      pw_q     <= 3'h0;
    end else begin
      rx_en_q  <= I_RX_EN;
      cnt_q    <= (vld && cnt_c != `WOLFD_CNT_MAX) ? cnt_c + 7'h01 : cnt_c;
      crc_q    <= vld ? crc_nx : crc_c; // see R7
      uc_q     <= uc_c & ~(vld & in_da & (b != da_b)); // see R2
      bc_q     <= bc_c & ~(vld & in_da & ~is_ff); // see R2
      pat_ok_q <= pok_c & ~(vld & pat_bad); // see R11
      hit_q    <= hit_d;
      phase_q  <= phase_d;
      sync_q   <= sync_d;
      ab_q     <= ab_d;
      cp_q     <= cp_d;
      pw_q     <= pw_d;
    end
  end

  // Frame verdict at the end of the frame
  wire crc_good  = crc_q == `WOLFD_CRC_RES;
  wire long_hdr  = cnt_q >= `WOLFD_HDR_LEN;
  wire addr_ok   = long_hdr & ((uc_q & en_ucast) | (bc_q & en_bcast)); // see R2 R12
  wire magic_cand = eof & en_magic & hit_q & addr_ok;
  wire pat_cand  = eof & en_pat & pat_ok_q & (cnt_q >= `WOLFD_PAT_LEN);
  wire magic_set = magic_cand & crc_good; // see R7 R8
  wire pat_set   = pat_cand & crc_good; // see R7 R11
  wire crc_set   = (magic_cand | pat_cand) & ~crc_good;
  wire [`WOLFD_STS_W-1:0] sts_set = {crc_set, pat_set, magic_set};
  wire [`WOLFD_STS_W-1:0] sts_clr =
    sts_clr_any ? I_PWDATA[`WOLFD_STS_W-1:0] : `WOLFD_STS_RST;

  // Sticky status, a new event beats a same-cycle clear
  assign sts_d = (sts_q & ~sts_clr) | sts_set;

  // Status and wake outputs
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sts_q  <= `WOLFD_STS_RST;
      irq_q  <= 1'b0;
      gpio_q <= 1'b0;
    end else begin
      sts_q  <= sts_d;
      irq_q  <= |(sts_q & mask_q); // see R8
      gpio_q <= en_gpio & (sts_q[`WOLFD_STS_MAGIC] | sts_q[`WOLFD_STS_PAT]); // see R9
    end
  end

  assign O_PRDATA    = prdata_q;
  assign O_PREADY    = pready_q;
  assign O_PSLVERR   = pslverr_q;
  assign O_IRQ       = irq_q;
  assign O_WAKE_GPIO = gpio_q;

  // Checks
  sequence s_magic_set;
    magic_set;
  endsequence

  sequence s_cfg_write;
    wr && is_cfg;
  endsequence

  sync_entry_a: assert property ( // see R3
    $rose(phase_q == WOLFD_ADDR) |-> $past(sync_c) == `WOLFD_SYNC_LEN)
    else $error("address phase entered without full sync run");

  copy_count_a: assert property ( // see R4
    $rose(hit_q) && !en_pwd |-> $past(cp_c) == `WOLFD_COPY_LAST)
    else $error("match declared before sixteen copies");

  pwd_done_a: assert property ( // see R5
    $rose(hit_q) && en_pwd |->
      $past(phase_c == WOLFD_PWD && pw_c == `WOLFD_PWD_LAST))
    else $error("match declared before password done");

  crc_gate_a: assert property ( // see R7
    eof && !crc_good |=> !$rose(sts_q[`WOLFD_STS_MAGIC]))
    else $error("wake flagged on bad crc frame");

  wake_irq_a: assert property ( // see R8
    s_magic_set ##0 mask_q[`WOLFD_STS_MAGIC] |-> ##2 O_IRQ)
    else $error("wake frame gave no interrupt");

  wake_gpio_a: assert property ( // see R9
    s_magic_set ##0 en_gpio |-> ##2 O_WAKE_GPIO)
    else $error("wake frame gave no gpio level");

  pat_wake_a: assert property ( // see R11
    pat_cand && crc_good |=> sts_q[`WOLFD_STS_PAT])
    else $error("pattern frame not flagged");

  uc_filter_a: assert property ( // see R12
    eof && !en_ucast && !bc_q |=> !$rose(sts_q[`WOLFD_STS_MAGIC]))
    else $error("unicast wake while disabled");

  cfg_write_a: assert property ( // see R13
    s_cfg_write |=> cfg_q == $past(I_PWDATA[`WOLFD_CFG_W-1:0]))
    else $error("config write lost");

  addr_restart_a: assert property ( // see R14
    scan && phase_c == WOLFD_ADDR && b != mac_b |=>
      phase_q == WOLFD_SYNC && $stable(hit_q))
    else $error("address mismatch did not restart search");
endmodule : wolfd_top
`default_nettype wire

// file: inc/wolfd_cfg.svh
// Constants of the wake-frame detector: register map, fields, counts
// Contract
// R1 - Scan addressed frames when wake detection enabled
// R2 - Accept own-address or broadcast destination frames
// R3 - Sequence starts with six FFh bytes
// R4 - Then sixteen unbroken station address copies
// R5 - Optional password follows last address copy
// R6 - Sequence may start anywhere in payload
// R7 - Bad CRC suppresses any wake indication; code still raises O_IRQ through the CRC status bit when its mask bit is set
// R8 - Valid wake frame raises wake interrupt
// R9 - Optional general-purpose output on wake frame
// R10 - Detection works at 1000, 100, 10 Mb/s
// R11 - One 64-byte pattern also wakes
// R12 - Separate broadcast and unicast wake enables
// R13 - Config at index 134h, status 135h
// R14 - Six-byte password; any mismatch restarts search
`ifndef WOLFD_CFG_SVH
`define WOLFD_CFG_SVH

// Register indices, byte address is four times the index
`define WOLFD_IDX_CFG   10'h134
`define WOLFD_IDX_STS   10'h135
`define WOLFD_IDX_MASK  10'h136
`define WOLFD_IDX_MACLO 10'h137
`define WOLFD_IDX_MACHI 10'h138
`define WOLFD_IDX_PWDLO 10'h139
`define WOLFD_IDX_PWDHI 10'h13A
`define WOLFD_IDX_PMLO  10'h13B
`define WOLFD_IDX_PMHI  10'h13C
// Pattern words live at indices 140h to 14Fh
`define WOLFD_IDX_PAT   6'h14

// Configuration fields
`define WOLFD_CFG_MAGIC 0
`define WOLFD_CFG_BCAST 1
`define WOLFD_CFG_UCAST 2
`define WOLFD_CFG_PWD   3
`define WOLFD_CFG_PAT   4
`define WOLFD_CFG_GPIO  5
`define WOLFD_CFG_W     6
`define WOLFD_CFG_RST   6'h00

// Status fields
`define WOLFD_STS_MAGIC 0
`define WOLFD_STS_PAT   1
`define WOLFD_STS_CRC   2
`define WOLFD_STS_W     3
`define WOLFD_STS_RST   3'h0

// Frame and sequence counts
`define WOLFD_SYNC_BYTE 8'hFF
`define WOLFD_SYNC_LEN  3'h6
`define WOLFD_ADDR_LAST 3'h5
`define WOLFD_COPY_LAST 4'hF
`define WOLFD_PWD_LAST  3'h5
`define WOLFD_DA_LEN    7'h06
`define WOLFD_HDR_LEN   7'h0C
`define WOLFD_PAT_LEN   7'h40
`define WOLFD_CNT_MAX   7'h7F

// Reflected CRC-32 constants
`define WOLFD_CRC_POLY  32'hEDB88320
`define WOLFD_CRC_INIT  32'hFFFFFFFF
`define WOLFD_CRC_RES   32'hDEBB20E3

`endif

// file: inc/wolfd_pkg.sv
// Types shared by the wake-frame detector
`default_nettype none
package wolfd_pkg;
  typedef enum logic [2:0] {
    WOLFD_SYNC = 3'b001,
    WOLFD_ADDR = 3'b010,
    WOLFD_PWD  = 3'b100
  } wolfd_phase_t;
endpackage : wolfd_pkg
`default_nettype wire

// file: sim/tb_wake_on_lan_frame_detector.sv
// Self-checking bench of the wake-frame detector
`default_nettype none
`include "wolfd_cfg.svh"
module tb_wake_on_lan_frame_detector
  import wolfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire  logic [31:0] prdata;
  wire  logic  pready, pslverr, irq, gpio, rx_en, rx_vld;
  wire  logic [7:0]  rx_byte;
  int          mismatches = 0, num_checks = 0;
  logic [7:0]  lfsr = 8'h22, mac[6], pwd[6], pat[64], fr[$];
  logic [63:0] pmask;
  logic [5:0]  cfg;
  logic [2:0]  msk, exp_st = 3'h0;
  logic        er;

  // Clock, 8 ns period
  always #4 clk = ~clk;

  wolfd_top i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_RX_EN(rx_en), .I_RX_VLD(rx_vld),
    .I_RX_BYTE(rx_byte), .O_IRQ(irq), .O_WAKE_GPIO(gpio));

  wolfd_rx_src i_src (.i_clk(clk), .o_rx_en(rx_en), .o_rx_vld(rx_vld),
    .o_rx_byte(rx_byte));

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; waits for ready, only the watchdog ends a hang
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d, rd, er);
  endtask : wr

  task automatic rdc(input string nm, input logic [9:0] idx,
                     input logic [31:0] e);
    apb(1'b0, {idx, 2'b00}, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask : rdc

  task automatic set_cfg(input logic [5:0] v);
    cfg = v;
    wr(`WOLFD_IDX_CFG, {26'h0, v});
  endtask : set_cfg

  // Frame: DA, SA, filler, sync, copies, optional password (2 = bad)
  task automatic mk(input bit bc, input int copies, input int pm);
    fr.delete();
    for (int i = 0; i < 6; i++) fr.push_back(bc ? 8'hFF : mac[i]);
    for (int i = 0; i < 6; i++) fr.push_back(8'h10 + i[7:0]);
    repeat ((rnd() & 7) + 1) fr.push_back(rnd() & 8'h7F);
    repeat (6) fr.push_back(8'hFF);
    repeat (copies) for (int i = 0; i < 6; i++) fr.push_back(mac[i]);
    if (pm > 0) for (int i = 0; i < 6; i++)
      fr.push_back(pwd[i] ^ {7'h0, pm == 2 && i == 5});
    repeat (4) fr.push_back(rnd() & 8'h7F);
  endtask : mk

  // Reference model of one frame's status bits
  function automatic logic [2:0] model(input bit bad);
    bit uc, bc, m, p, ok;
    int n, k;
    n = fr.size();
    uc = 1;
    bc = 1;
    m = 0;
    for (int i = 0; i < 6; i++) begin
      uc &= fr[i] == mac[i];
      bc &= fr[i] == 8'hFF;
    end
    k = 102 + (cfg[3] ? 6 : 0);
    if (cfg[0] && ((uc && cfg[2]) || (bc && cfg[1])))
      for (int s = 12; s + k <= n; s++) begin
        ok = 1;
        for (int j = 0; j < k; j++) ok &= fr[s+j] == (j < 6 ? 8'hFF :
          j < 102 ? mac[(j-6) % 6] : pwd[j-102]);
        m |= ok;
      end
    p = cfg[4] && n + 4 >= 64;
    for (int j = 0; j < 64; j++) if (pmask[j] && j < n) p &= fr[j] == pat[j];
    return bad ? {m | p, 2'b00} : {1'b0, p, m};
  endfunction : model

  // Send the current frame and compare every result, then clear
  task automatic run(input bit bad, input int gap);
    logic [2:0] st;
    st = model(bad);
    i_src.send(fr, bad, gap);
    exp_st = st;
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, |(exp_st & msk)}, {31'h0, irq});
    chk("gpio", {31'h0, cfg[5] & |exp_st[1:0]}, {31'h0, gpio});
    rdc("status", `WOLFD_IDX_STS, {29'h0, exp_st});
    wr(`WOLFD_IDX_STS, 32'h7);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask : run

  // Watchdog over the whole run
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    pmask = 64'h0;
    cfg = 6'h0;
    @(posedge clk);
    rdc("cfg reset", `WOLFD_IDX_CFG, 32'h0);
    rdc("sts reset", `WOLFD_IDX_STS, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0, rd, er);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, er});
    for (int i = 0; i < 6; i++) begin
      mac[i] = 8'h02 + 8'h13 * i[7:0];
      pwd[i] = 8'h2A + i[7:0];
    end
    wr(`WOLFD_IDX_MACLO, {mac[3], mac[2], mac[1], mac[0]});
    wr(`WOLFD_IDX_MACHI, {16'h0, mac[5], mac[4]});
    wr(`WOLFD_IDX_PWDLO, {pwd[3], pwd[2], pwd[1], pwd[0]});
    wr(`WOLFD_IDX_PWDHI, {16'h0, pwd[5], pwd[4]});
    msk = 3'h7;
    wr(`WOLFD_IDX_MASK, 32'h7);
    set_cfg(6'h25);
    rdc("cfg", `WOLFD_IDX_CFG, 32'h25);
    for (int g = 0; g < 3; g++) begin
      mk(0, 16, 0);
      run(0, (g == 0) ? 0 : (g == 1) ? 9 : 99);
    end
    mk(0, 16, 0);
    run(1, 0);
    mk(1, 16, 0);
    run(0, 0);
    set_cfg(6'h23);
    mk(1, 16, 0);
    run(0, 0);
    mk(0, 16, 0);
    run(0, 0);
    set_cfg(6'h2D);
    for (int pm = 0; pm < 3; pm++) begin
      mk(0, 16, pm);
      run(0, 0);
    end
    set_cfg(6'h05);
    mk(0, 15, 0);
    run(0, 0);
    msk = 3'h6;
    wr(`WOLFD_IDX_MASK, 32'h6);
    mk(0, 16, 0);
    run(0, 0);
    for (int n = 0; n < 64; n++) pat[n] = rnd();
    for (int w = 0; w < 16; w++)
      wr({`WOLFD_IDX_PAT, w[3:0]}, {pat[4*w+3], pat[4*w+2], pat[4*w+1],
        pat[4*w]});
    pmask = 64'hFFFFFFFF_F0F0FFFF;
    wr(`WOLFD_IDX_PMLO, pmask[31:0]);
    wr(`WOLFD_IDX_PMHI, pmask[63:32]);
    set_cfg(6'h30);
    for (int t = 0; t < 2; t++) begin
      fr.delete();
      foreach (pat[n]) fr.push_back(pat[n]);
      repeat (4) fr.push_back(rnd());
      fr[63] = fr[63] ^ t[7:0];
      run(0, 0);
    end
    end_of_test();
  end
endmodule : tb_wake_on_lan_frame_detector
`default_nettype wire

// file: sim/wolfd_rx_src.sv
// Receive-side byte source that feeds whole frames with their FCS
`default_nettype none
module wolfd_rx_src (
  // Clock
  input  wire logic       i_clk,
  // Frame bytes toward the detector
  output logic            o_rx_en,
  output logic            o_rx_vld,
  output logic      [7:0] o_rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    o_rx_en   = 1'b0;
    o_rx_vld  = 1'b0;
    o_rx_byte = 8'h00;
  end

  // One reflected CRC-32 byte step, kept apart from the design's own
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return c;
  endfunction : crc_step

  // Sends one frame; gap idle cycles between strobes model slow links
  task automatic send(input logic [7:0] q[$], input bit bad, input int gap);
    logic [31:0] c;
    logic [7:0]  f[$];
    c = 32'hFFFFFFFF;
    f = q;
    foreach (q[i]) c = crc_step(c, q[i]);
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) f.push_back(c[8*i +: 8]);
    foreach (f[i]) begin
      o_rx_en   <= 1'b1;
      o_rx_vld  <= 1'b1;
      o_rx_byte <= f[i];
      @(posedge i_clk);
      if (gap > 0) begin
        o_rx_vld  <= 1'b0;
        o_rx_byte <= ~f[i]; // Stale byte never repeats the last value
        repeat (gap) @(posedge i_clk);
      end
    end
    o_rx_en   <= 1'b0; // At least one low cycle between frames
    o_rx_vld  <= 1'b0;
    o_rx_byte <= ~f[f.size()-1];
    @(posedge i_clk);
  endtask : send
endmodule : wolfd_rx_src
`default_nettype wire
